// ### verilog/accr_regs.sv
// Channel five gain and channel six configuration and offset calibration registers
//
// Overview of operation
// RULE1: Upper gain word forms gain bits 23:8
// RULE2: Lower gain byte forms gain bits 7:0
// RULE3: Gain value is unsigned, unity at midscale
// RULE4: Offset value joined, two's complement
// RULE5: Phase delay is signed bits 15:6
// RULE6: Bit 2 disables DC block for channel
// RULE7: Bits 1:0 select converter input source
// RULE8: Configuration bits 5:3 read as zero
// RULE9: Low byte of lower words reads zero
// RULE10: Configuration resets to all zeros
// RULE11: Upper gain word resets to unity
// RULE12: Writes to reserved bits are ignored
`timescale 1ns/1ps
`default_nettype none
`include "accr_defs.svh"

module accr_regs #(
    parameter int ADDR_W = 8
) (
    // Clock, reset, enable
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    // Register port
    input wire accr_pkg::accr_bus_req_t bus_req_in,
    output logic [15:0] rd_data_out,
    output logic rd_valid_out,
    // Global setting from elsewhere in the device
    input wire logic global_dc_block_setting_in,
    // Calibration and configuration values
    output logic [23:0] ch5_gain_out,
    output logic signed [23:0] ch6_offset_out,
    output accr_pkg::accr_ch_cfg_t ch6_config_out
);
    import accr_pkg::*;

    // ==========================================================
    // Elaboration check
    if (ADDR_W < `ACCR_MIN_ADDR_W || ADDR_W > 8) begin : g_bad_addr_w
        $error("ADDR_W must lie between 6 and 8");
    end

    // ==========================================================
    // Storage
    logic [15:0] ch5_gain_upper_bits_r;
    logic [7:0] ch5_gain_lower_bits_r;
    logic [9:0] ch6_phase_delay_r;
    logic ch6_dc_block_off_r;
    logic [1:0] ch6_input_select_r;
    logic [15:0] ch6_offset_upper_bits_r;
    logic [7:0] ch6_offset_lower_bits_r;
    logic [15:0] rd_data_nxt;
    logic [23:0] offset_raw;
    logic [7:0] addr;

    // Address bits above the port width are taken as zero
    assign addr = 8'(bus_req_in.addr[ADDR_W-1:0]);

    // Write strobe aimed at one register
    function automatic logic wr_hit(input accr_bus_req_t req, input logic [7:0] a,
                                    input logic [7:0] target);
        wr_hit = req.wr && (a == target);
    endfunction

    // Lower calibration word: field in the upper byte, reserved byte reads zero
    function automatic logic [15:0] low_word(input logic [7:0] field);
        low_word = {field, 8'h00};
    endfunction

    // ==========================================================
    // Channel five gain, upper word
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            ch5_gain_upper_bits_r <= `ACCR_RST_CH5_GAIN_HIGH; // RULE11
        end else if (ce_in && wr_hit(bus_req_in, addr, `ACCR_ADDR_CH5_GAIN_HIGH)) begin
            ch5_gain_upper_bits_r <= bus_req_in.wdata;
        end
    end

    // Channel five gain, lower byte; the reserved low byte is not stored
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            ch5_gain_lower_bits_r <= `ACCR_RST_CH5_GAIN_LOW;
        end else if (ce_in && wr_hit(bus_req_in, addr, `ACCR_ADDR_CH5_GAIN_LOW)) begin
            ch5_gain_lower_bits_r <= bus_req_in.wdata[`ACCR_LOW_FIELD_MSB:`ACCR_LOW_FIELD_LSB]; // RULE12
        end
    end

    // ==========================================================
    // Channel six configuration; bits 5:3 have no storage at all
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            ch6_phase_delay_r <= `ACCR_RST_CH6_PHASE; // RULE10
            ch6_dc_block_off_r <= `ACCR_RST_CH6_DC_OFF; // RULE10
            ch6_input_select_r <= `ACCR_RST_CH6_SEL; // RULE10
        end else if (ce_in && wr_hit(bus_req_in, addr, `ACCR_ADDR_CH6_CONFIG)) begin
            ch6_phase_delay_r <= bus_req_in.wdata[`ACCR_PHASE_MSB:`ACCR_PHASE_LSB]; // RULE5
            ch6_dc_block_off_r <= bus_req_in.wdata[`ACCR_DC_OFF_BIT]; // RULE6
            ch6_input_select_r <= bus_req_in.wdata[`ACCR_SEL_MSB:`ACCR_SEL_LSB]; // RULE7
        end
    end

    // ==========================================================
    // Channel six offset, upper word and lower byte
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            ch6_offset_upper_bits_r <= `ACCR_RST_CH6_OFFSET_HIGH;
        end else if (ce_in && wr_hit(bus_req_in, addr, `ACCR_ADDR_CH6_OFFSET_HIGH)) begin
            ch6_offset_upper_bits_r <= bus_req_in.wdata;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            ch6_offset_lower_bits_r <= `ACCR_RST_CH6_OFFSET_LOW;
        end else if (ce_in && wr_hit(bus_req_in, addr, `ACCR_ADDR_CH6_OFFSET_LOW)) begin
            ch6_offset_lower_bits_r <= bus_req_in.wdata[`ACCR_LOW_FIELD_MSB:`ACCR_LOW_FIELD_LSB]; // RULE12
        end
    end

    // ==========================================================
    // Read decode; unmapped addresses read zero
    always_comb begin
        rd_data_nxt = 16'h0000;
        unique case (addr)
            `ACCR_ADDR_CH5_GAIN_HIGH: begin
                rd_data_nxt = ch5_gain_upper_bits_r;
            end
            `ACCR_ADDR_CH5_GAIN_LOW: begin
                rd_data_nxt = low_word(ch5_gain_lower_bits_r); // RULE9
            end
            `ACCR_ADDR_CH6_CONFIG: begin
                // Reserved bits 5:3 are tied low
                rd_data_nxt = {ch6_phase_delay_r, 3'h0, ch6_dc_block_off_r,
                               ch6_input_select_r}; // RULE8
            end
            `ACCR_ADDR_CH6_OFFSET_HIGH: begin
                rd_data_nxt = ch6_offset_upper_bits_r;
            end
            `ACCR_ADDR_CH6_OFFSET_LOW: begin
                rd_data_nxt = low_word(ch6_offset_lower_bits_r); // RULE9
            end
            default: begin
                rd_data_nxt = 16'h0000;
            end
        endcase
    end

    // Read data stands in the cycle after the strobe, zero after other enabled edges; a low enable holds them
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            rd_data_out <= 16'h0000;
            rd_valid_out <= 1'b0;
        end else if (ce_in) begin
            rd_data_out <= bus_req_in.rd ? rd_data_nxt : 16'h0000;
            rd_valid_out <= bus_req_in.rd;
        end
    end

    // ==========================================================
    // Joined calibration values
    // Gain is unsigned: 800000h is unity, range 0 to just under 2
    accr_cal_join #(
        .RESET_VAL(`ACCR_RST_GAIN_VALUE)
    ) u_gain_join (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .upper_in(ch5_gain_upper_bits_r), // RULE1
        .lower_in(ch5_gain_lower_bits_r), // RULE2
        .cal_val_out(ch5_gain_out) // RULE3
    );

    // Offset is the same join, read as two's complement by the consumer
    accr_cal_join #(
        .RESET_VAL(`ACCR_RST_OFFSET_VALUE)
    ) u_offset_join (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .upper_in(ch6_offset_upper_bits_r),
        .lower_in(ch6_offset_lower_bits_r),
        .cal_val_out(offset_raw)
    );

    assign ch6_offset_out = $signed(offset_raw); // RULE4

    // Configuration decode, registered
    accr_cfg_split u_cfg_split (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .phase_in(ch6_phase_delay_r),
        .dc_off_in(ch6_dc_block_off_r),
        .sel_in(ch6_input_select_r),
        .global_dc_block_setting_in(global_dc_block_setting_in),
        .cfg_out(ch6_config_out)
    );

    // ==========================================================
    // Assertions
    property p_gain_upper;
        @(posedge ref_clk_in) disable iff (rst_in)
        (ce_in && wr_hit(bus_req_in, addr, `ACCR_ADDR_CH5_GAIN_HIGH)) ##1 ce_in
        |=> ch5_gain_out[23:8] == $past(bus_req_in.wdata, 2);
    endproperty
    a_gain_upper: assert property (p_gain_upper) else $error("gain upper bits wrong"); // RULE1

    property p_gain_lower;
        @(posedge ref_clk_in) disable iff (rst_in)
        (ce_in && wr_hit(bus_req_in, addr, `ACCR_ADDR_CH5_GAIN_LOW)) ##1 ce_in
        |=> ch5_gain_out[7:0] == $past(bus_req_in.wdata[15:8], 2);
    endproperty
    a_gain_lower: assert property (p_gain_lower) else $error("gain lower bits wrong"); // RULE2

    property p_gain_unsigned;
        @(posedge ref_clk_in) disable iff (rst_in)
        ($past(ce_in) && !$past(rst_in))
        |-> ch5_gain_out == $past({ch5_gain_upper_bits_r, ch5_gain_lower_bits_r});
    endproperty
    a_gain_unsigned: assert property (p_gain_unsigned) else $error("gain value mismatch"); // RULE3

    property p_offset_join;
        @(posedge ref_clk_in) disable iff (rst_in)
        ($past(ce_in) && !$past(rst_in))
        |-> ch6_offset_out == $signed($past({ch6_offset_upper_bits_r,
                                             ch6_offset_lower_bits_r}))
            && ch6_offset_out[23] == $past(ch6_offset_upper_bits_r[15]);
    endproperty
    a_offset_join: assert property (p_offset_join) else $error("offset value mismatch"); // RULE4

    property p_phase_field;
        @(posedge ref_clk_in) disable iff (rst_in)
        (ce_in && wr_hit(bus_req_in, addr, `ACCR_ADDR_CH6_CONFIG)) ##1 ce_in
        |=> ch6_config_out.ch6_phase_delay == $signed($past(bus_req_in.wdata[15:6], 2))
            && ch6_config_out.ch6_input_select == accr_src_t'($past(bus_req_in.wdata[1:0], 2));
    endproperty
    a_phase_field: assert property (p_phase_field) else $error("phase or input wrong"); // RULE5

    property p_dc_block;
        @(posedge ref_clk_in) disable iff (rst_in)
        ($past(ce_in) && !$past(rst_in))
        |-> ch6_config_out.dc_block_active ==
            ($past(global_dc_block_setting_in) && !$past(ch6_dc_block_off_r));
    endproperty
    a_dc_block: assert property (p_dc_block) else $error("DC block state wrong"); // RULE6

    property p_input_sel;
        @(posedge ref_clk_in) disable iff (rst_in)
        ($past(ce_in) && !$past(rst_in))
        |-> ch6_config_out.ch6_input_select == accr_src_t'($past(ch6_input_select_r));
    endproperty
    a_input_sel: assert property (p_input_sel) else $error("input select wrong"); // RULE7

    property p_cfg_rsvd;
        @(posedge ref_clk_in) disable iff (rst_in)
        (ce_in && bus_req_in.rd && addr == `ACCR_ADDR_CH6_CONFIG)
        |=> rd_valid_out && rd_data_out[5:3] == 3'h0;
    endproperty
    a_cfg_rsvd: assert property (p_cfg_rsvd) else $error("config reserved bits set"); // RULE8

    property p_low_rsvd;
        @(posedge ref_clk_in) disable iff (rst_in)
        (ce_in && bus_req_in.rd && (addr == `ACCR_ADDR_CH5_GAIN_LOW ||
                                    addr == `ACCR_ADDR_CH6_OFFSET_LOW))
        |=> rd_data_out[7:0] == 8'h00;
    endproperty
    a_low_rsvd: assert property (p_low_rsvd) else $error("low byte not zero"); // RULE9

    property p_cfg_reset;
        @(posedge ref_clk_in) disable iff (rst_in)
        $past(rst_in) |-> ch6_phase_delay_r == 10'h000 && !ch6_dc_block_off_r
                          && ch6_input_select_r == 2'h0;
    endproperty
    a_cfg_reset: assert property (p_cfg_reset) else $error("config reset wrong"); // RULE10

    property p_gain_reset;
        @(posedge ref_clk_in) disable iff (rst_in)
        $past(rst_in) |-> ch5_gain_upper_bits_r == 16'h8000;
    endproperty
    a_gain_reset: assert property (p_gain_reset) else $error("gain reset wrong"); // RULE11

    property p_rsvd_write;
        @(posedge ref_clk_in) disable iff (rst_in)
        (ce_in && wr_hit(bus_req_in, addr, `ACCR_ADDR_CH6_CONFIG))
        ##1 (ce_in && bus_req_in.rd && addr == `ACCR_ADDR_CH6_CONFIG)
        |=> rd_data_out == ($past(bus_req_in.wdata, 2) & 16'hffc7);
    endproperty
    a_rsvd_write: assert property (p_rsvd_write) else $error("reserved write stored"); // RULE12

    // Main scenarios
    c_gain_write: cover property (@(posedge ref_clk_in) disable iff (rst_in)
        ce_in && wr_hit(bus_req_in, addr, `ACCR_ADDR_CH5_GAIN_HIGH));
    c_dc_off: cover property (@(posedge ref_clk_in) disable iff (rst_in)
        global_dc_block_setting_in && ch6_config_out.ch6_dc_block_off);
    c_neg_offset: cover property (@(posedge ref_clk_in) disable iff (rst_in)
        ch6_offset_out[23]);

endmodule
`default_nettype wire

// ### verilog/accr_defs.svh
// Offsets, field positions and reset values of the channel calibration registers
`ifndef ACCR_DEFS_SVH
`define ACCR_DEFS_SVH

// ==========================================================
// Register offsets (word addresses)
`define ACCR_ADDR_CH5_GAIN_HIGH 8'h25
`define ACCR_ADDR_CH5_GAIN_LOW 8'h26
`define ACCR_ADDR_CH6_CONFIG 8'h27
`define ACCR_ADDR_CH6_OFFSET_HIGH 8'h28
`define ACCR_ADDR_CH6_OFFSET_LOW 8'h29

// ==========================================================
// Reset values
`define ACCR_RST_CH5_GAIN_HIGH 16'h8000
`define ACCR_RST_CH5_GAIN_LOW 8'h00
`define ACCR_RST_CH6_PHASE 10'h000
`define ACCR_RST_CH6_DC_OFF 1'b0
`define ACCR_RST_CH6_SEL 2'h0
`define ACCR_RST_CH6_OFFSET_HIGH 16'h0000
`define ACCR_RST_CH6_OFFSET_LOW 8'h00
`define ACCR_RST_GAIN_VALUE 24'h800000
`define ACCR_RST_OFFSET_VALUE 24'h000000

// ==========================================================
// Field positions
`define ACCR_PHASE_MSB 15
`define ACCR_PHASE_LSB 6
`define ACCR_RSVD_CFG_MSB 5
`define ACCR_RSVD_CFG_LSB 3
`define ACCR_DC_OFF_BIT 2
`define ACCR_SEL_MSB 1
`define ACCR_SEL_LSB 0
`define ACCR_LOW_FIELD_MSB 15
`define ACCR_LOW_FIELD_LSB 8
`define ACCR_RSVD_LOW_MSB 7
`define ACCR_RSVD_LOW_LSB 0
`define ACCR_MIN_ADDR_W 6

`endif

// ### verilog/accr_pkg.sv
// Types shared by the channel calibration register bank
package accr_pkg;

    // ==========================================================
    // Converter input source of channel six
    typedef enum logic [1:0] {
        ACCR_SRC_PINS,
        ACCR_SRC_SHORTED,
        ACCR_SRC_POS_TEST,
        ACCR_SRC_NEG_TEST
    } accr_src_t;

    // ==========================================================
    // Register port request from the host side
    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } accr_bus_req_t;

    // Decoded channel six configuration
    typedef struct packed {
        logic signed [9:0] ch6_phase_delay;
        logic ch6_dc_block_off;
        logic dc_block_active;
        accr_src_t ch6_input_select;
    } accr_ch_cfg_t;

endpackage

// ### verilog/accr_cal_join.sv
// Joins an upper calibration word and a lower byte into a registered 24-bit value
`timescale 1ns/1ps
`default_nettype none

module accr_cal_join #(
    parameter logic [23:0] RESET_VAL = 24'h000000
) (
    // Clock, reset, enable
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    // Register contents
    input wire logic [15:0] upper_in,
    input wire logic [7:0] lower_in,
    // Joined value
    output logic [23:0] cal_val_out
);

    // ==========================================================
    // Joined value
    // Registered so the consumer sees a value that never glitches mid-update
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            cal_val_out <= RESET_VAL;
        end else if (ce_in) begin
            cal_val_out <= {upper_in, lower_in};
        end
    end

endmodule
`default_nettype wire

// ### verilog/accr_cfg_split.sv
// Decodes the channel six configuration fields into a registered struct
`timescale 1ns/1ps
`default_nettype none

module accr_cfg_split (
    // Clock, reset, enable
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    // Stored fields
    input wire logic [9:0] phase_in,
    input wire logic dc_off_in,
    input wire logic [1:0] sel_in,
    input wire logic global_dc_block_setting_in,
    // Decoded configuration
    output accr_pkg::accr_ch_cfg_t cfg_out
);
    import accr_pkg::*;

    // ==========================================================
    // Decoded configuration
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            cfg_out <= '0;
        end else if (ce_in) begin
            cfg_out.ch6_phase_delay <= $signed(phase_in);
            cfg_out.ch6_dc_block_off <= dc_off_in;
            // Per-channel disable overrides the global setting
            cfg_out.dc_block_active <= global_dc_block_setting_in & ~dc_off_in;
            cfg_out.ch6_input_select <= accr_src_t'(sel_in);
        end
    end

endmodule
`default_nettype wire

// ### tb/accr_regs_bench.sv
// Self-checking bench for the channel calibration register bank
`timescale 1ns/1ps
`default_nettype none

module accr_regs_bench;
    import accr_pkg::*;

    // ==========================================================
    // Row of the ordinary cases: write a word, expect the row's read value back on read
    typedef struct {
        logic [7:0] addr;
        logic [15:0] wdata;
        logic [15:0] rdata;
    } accr_row_t;

    // ==========================================================
    // Stimulus and observed signals
    logic ref_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic ce_in = 1'b1;
    logic global_dc = 1'b1;
    accr_bus_req_t req = '0;
    logic [15:0] rd_data;
    logic rd_valid;
    logic [23:0] gain;
    logic signed [23:0] offset;
    accr_ch_cfg_t cfg;
    int errors = 0;
    int num_checks = 0;

    // Reserved bits drop to zero; an unmapped place reads zero
    accr_row_t rows [8] = '{
        '{8'h25, 16'hffff, 16'hffff},
        '{8'h26, 16'hffff, 16'hff00},
        '{8'h27, 16'hffff, 16'hffc7},
        '{8'h28, 16'ha5c3, 16'ha5c3},
        '{8'h29, 16'h5aff, 16'h5a00},
        '{8'h27, 16'h0038, 16'h0000},
        '{8'h24, 16'h1234, 16'h0000},
        '{8'h3f, 16'hbeef, 16'h0000}
    };

    // ==========================================================
    // Design under test
    accr_regs #(
        .ADDR_W(8)
    ) dut_u (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .bus_req_in(req),
        .rd_data_out(rd_data),
        .rd_valid_out(rd_valid),
        .global_dc_block_setting_in(global_dc),
        .ch5_gain_out(gain),
        .ch6_offset_out(offset),
        .ch6_config_out(cfg)
    );

    // 25 MHz clock
    always #20 ref_clk_in = ~ref_clk_in;

    // ==========================================================
    // Shared tasks
    task automatic test_done();
        if (errors == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One-cycle write strobe; the request is taken at the second edge
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk_in);
        req.addr <= a;
        req.wdata <= d;
        req.wr <= 1'b1;
        @(posedge ref_clk_in);
        req.wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so sample there
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
        @(posedge ref_clk_in);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge ref_clk_in);
        req.rd <= 1'b0;
        #1;
        chk(24'(rd_data), 24'(exp));
        chk(24'(rd_valid), 24'h1);
    endtask

    // Write then read the same place with no gap between the strobes
    task automatic wr_rd_chk(input logic [7:0] a, input logic [15:0] d,
                             input logic [15:0] exp);
        @(posedge ref_clk_in);
        req.addr <= a;
        req.wdata <= d;
        req.wr <= 1'b1;
        @(posedge ref_clk_in);
        req.wr <= 1'b0;
        req.rd <= 1'b1;
        @(posedge ref_clk_in);
        req.rd <= 1'b0;
        #1;
        chk(24'(rd_data), 24'(exp));
    endtask

    // Value outputs lag the register by one further edge
    task automatic settle();
        @(posedge ref_clk_in);
        #1;
    endtask

    // Guard against a hang anywhere in the sequence
    initial begin
        repeat (5000) @(posedge ref_clk_in);
        errors++;
        $display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
        test_done();
    end

    // ==========================================================
    // Main sequence
    initial begin
        logic [9:0] ph;
        logic dc;
        logic [1:0] s;
        repeat (16) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        settle();
        // Defaults straight after reset
        chk(gain, 24'h800000);
        chk(24'(offset), 24'h000000);
        // DC block becomes active from the global setting on the first enabled edge
        chk(24'(cfg), 24'({11'h000, global_dc, 2'h0}));
        rd_chk(8'h25, 16'h8000);
        rd_chk(8'h26, 16'h0000);
        rd_chk(8'h27, 16'h0000);
        rd_chk(8'h28, 16'h0000);
        rd_chk(8'h29, 16'h0000);

        // Ordinary write and readback cases
        for (int i = 0; i < 8; i++) begin
            wr(rows[i].addr, rows[i].wdata);
            rd_chk(rows[i].addr, rows[i].rdata);
        end

        // Gain word joins upper word and upper byte of the lower word
        wr(8'h25, 16'h1234);
        wr(8'h26, 16'h56a5);
        settle();
        chk(gain, 24'h123456);
        wr(8'h25, 16'hffff);
        wr(8'h26, 16'hff00);
        settle();
        chk(gain, 24'hffffff);

        // Offset is two's complement: most negative plus one
        wr(8'h28, 16'h8000);
        wr(8'h29, 16'h0100);
        settle();
        chk(24'(offset), 24'h800001);
        chk(24'(offset < 0), 24'h1);

        // Every input select code, with DC-block and global setting varied
        for (int i = 0; i < 4; i++) begin
            s = i[1:0];
            dc = i[0];
            ph = 10'h200 + 10'(i);
            @(posedge ref_clk_in);
            global_dc <= i[1];
            wr(8'h27, {ph, 3'b111, dc, s});
            settle();
            chk(24'(cfg), 24'({ph, dc, i[1] & ~dc, s}));
            chk(24'(cfg.ch6_phase_delay < 0), 24'h1);
        end

        // Strobes while the clock enable is low are ignored
        @(posedge ref_clk_in);
        ce_in <= 1'b0;
        wr(8'h28, 16'h1111);
        @(posedge ref_clk_in);
        ce_in <= 1'b1;
        rd_chk(8'h28, 16'h8000);

        // Write then read with no gap; read data vanish a cycle later
        wr_rd_chk(8'h29, 16'hc3ff, 16'hc300);
        settle();
        chk(24'({rd_valid, rd_data}), 24'h000000);
        wr_rd_chk(8'h27, 16'hffff, 16'hffc7);

        // Reset in mid-run brings every default back
        @(posedge ref_clk_in);
        rst_in <= 1'b1;
        repeat (2) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        settle();
        chk(gain, 24'h800000);
        chk(24'(offset), 24'h000000);
        chk(24'(cfg), 24'({11'h000, global_dc, 2'h0}));
        rd_chk(8'h27, 16'h0000);
        test_done();
    end

endmodule
`default_nettype wire
